// ===== core/flash_cmd_pkg.sv
// constants for the flash command interpreter: opcodes, table header, fields
// assumes nothing beyond a SystemVerilog compiler
package flash_cmd_pkg;

    // opcodes
    localparam logic [7:0] RESUME_CMD = 8'h30;
    localparam logic [7:0] NULL_CMD = 8'h00;
    localparam logic [7:0] RESET_ARM_CMD = 8'h66;
    localparam logic [7:0] RESET_CMD = 8'h99;
    localparam logic [7:0] PARAM_TABLE_READ_CMD = 8'h5A;
    localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;

    // frame shape
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] SPI_STEP = 4'h1;
    localparam logic [3:0] QPI_STEP = 4'h4;
    localparam logic [1:0] ADDR_BYTES = 2'h3;
    localparam logic [3:0] SPI_OUT_REST = 4'h7;
    localparam logic [3:0] QPI_OUT_REST = 4'h1;
    localparam logic [3:0] SPI_OE = 4'h2;
    localparam logic [3:0] QPI_OE = 4'hF;

    // security register field positions
    localparam int PROG_SUSP_BIT = 2;
    localparam int ERASE_SUSP_BIT = 3;

    // maker id byte of the second header; value is arbitrary
    localparam logic [7:0] MAKER_ID = 8'h5D;
    localparam logic [7:0] UNUSED_BYTE = 8'hFF;
    localparam int HDR_BYTES = 32;

    // header area, byte n at [8n+:8]
    localparam logic [255:0] HDR_AREA = {
        8'hFF, 8'h00, 8'h00, 8'hC0, 8'h02, 8'h01, 8'h00, 8'h84,
        8'hFF, 8'h00, 8'h01, 8'h10, 8'h04, 8'h01, 8'h00, MAKER_ID,
        8'hFF, 8'h00, 8'h00, 8'h30, 8'h10, 8'h01, 8'h06, 8'h00,
        8'hFF, 8'h02, 8'h01, 8'h06, 8'h50, 8'h44, 8'h46, 8'h53
    };

    typedef enum logic [2:0] {
        ST_OPCODE,
        ST_ADDR,
        ST_DUMMY,
        ST_DATA,
        ST_HOLD
    } link_state_t;

endpackage

// ===== core/link_sampler.sv
// two-flop synchroniser for the link pins plus edge finder for clock and select
// assumes pins are asynchronous to clk and the link clock is well below clk/4
`timescale 1ns/1ps
module link_sampler (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic [3:0] io_in,
    output logic cs_n_s,
    output logic cs_rise,
    output logic sclk_rise,
    output logic sclk_fall,
    output logic [3:0] io_s
);
    logic [5:0] meta_ff;
    logic [5:0] sync_ff;
    logic sclk_d_ff;
    logic cs_n_d_ff;

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_ff <= 6'h01;
            sync_ff <= 6'h01;
        end else begin
            meta_ff <= {io_in, sclk_pin, cs_n_pin};
            sync_ff <= meta_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sclk_d_ff <= 1'b0;
            cs_n_d_ff <= 1'b1;
        end else begin
            sclk_d_ff <= sync_ff[1];
            cs_n_d_ff <= sync_ff[0];
        end
    end

    assign cs_n_s = sync_ff[0];
    assign io_s = sync_ff[5:2];
    assign sclk_rise = sync_ff[1] & ~sclk_d_ff;
    assign sclk_fall = ~sync_ff[1] & sclk_d_ff;
    assign cs_rise = sync_ff[0] & ~cs_n_d_ff;
endmodule

// ===== core/param_table_rom.sv
// parameter table header area; bytes past the header read as unused
// assumes a byte address from the command core
`timescale 1ns/1ps
module param_table_rom
    import flash_cmd_pkg::*;
(
    input wire logic [23:0] rd_addr,
    output logic [7:0] rd_byte
);
    logic [7:0] entry [HDR_BYTES];

    // one table entry per byte
    genvar gi;
    generate
        for (gi = 0; gi < HDR_BYTES; gi++) begin : g_entry
            assign entry[gi] = HDR_AREA[8*gi +: 8];
        end
    endgenerate

    always_comb begin
        if (rd_addr < 24'(HDR_BYTES)) begin
            rd_byte = entry[rd_addr[4:0]];
        end else begin
            rd_byte = UNUSED_BYTE;
        end
    end
endmodule

// ===== core/flash_cmd_core.sv
// command interpreter for resume, null, software reset and parameter table read
// assumes host link pins asynchronous to clk; suspend and write-done come from the array engine
//
// Contract
// - resume opcode continues op, clears suspend flags
// - clear whichever suspend flag was set
// - busy held after resume until write done
// - resume needs no write enable
// - resume ignored while performance mode active
// - null only cancels reset arming
// - opcode 8 clocks SPI, 2 clocks QPI
// - software reset restores power-on defaults
// - reset only straight after reset arm
// - reset aborts ongoing program or erase
// - table read: opcode, 3 address, 1 dummy
// - select high ends read, releases output
// - revision bytes and unused byte 07h
// - header count byte is 02h
// - first header: standard table fields
// - second header: maker table fields
// - third header: four-byte address table
// - suspend flags at security bits 2,3
`timescale 1ns/1ps
module flash_cmd_core
    import flash_cmd_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic qpi_mode,
    input wire logic perf_enhance_mode,
    input wire logic program_suspend_req,
    input wire logic erase_suspend_req,
    input wire logic op_in_progress,
    input wire logic write_done,
    output logic [7:0] security_reg,
    output logic busy,
    output logic resume_pulse,
    output logic soft_reset_pulse,
    output logic abort_pulse,
    output logic reset_armed
);
    logic cs_n_s;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic [3:0] io_s;
    logic [7:0] rom_byte;

    link_state_t state_ff;
    logic [3:0] bit_cnt_ff;
    logic [1:0] byte_cnt_ff;
    logic [7:0] sh_ff;
    logic [7:0] cmd_ff;
    logic extra_ff;
    logic [23:0] addr_ff;
    logic [7:0] out_sh_ff;
    logic [3:0] out_cnt_ff;
    logic [3:0] io_out_ff;
    logic [3:0] io_oe_ff;
    logic arm_ff;
    logic program_suspended_flag_ff;
    logic erase_suspended_flag_ff;
    logic busy_ff;
    logic resume_ff;
    logic soft_reset_ff;
    logic abort_ff;

    logic [3:0] step;
    logic [3:0] nxt_bits;
    logic [7:0] nxt_sh;
    logic byte_done;
    logic take_bit;
    logic opcode_done;
    logic exact_end;
    logic exec_resume;
    logic exec_reset;
    logic exec_null;
    logic load_byte;

    link_sampler u_sampler (
        .clk(clk),
        .sys_rst(sys_rst),
        .cs_n_pin(cs_n_pin),
        .sclk_pin(sclk_pin),
        .io_in(io_in),
        .cs_n_s(cs_n_s),
        .cs_rise(cs_rise),
        .sclk_rise(sclk_rise),
        .sclk_fall(sclk_fall),
        .io_s(io_s)
    );

    param_table_rom u_rom (
        .rd_addr(addr_ff),
        .rd_byte(rom_byte)
    );

    always_comb begin
        step = qpi_mode ? QPI_STEP : SPI_STEP;
        nxt_bits = bit_cnt_ff + step;
        if (qpi_mode) begin
            nxt_sh = {sh_ff[3:0], io_s};
        end else begin
            nxt_sh = {sh_ff[6:0], io_s[0]};
        end
        take_bit = sclk_rise & ~cs_n_s;
        byte_done = take_bit & (nxt_bits == BITS_PER_BYTE);
        opcode_done = byte_done & (state_ff == ST_OPCODE);
    end

    // frame ended exactly on the opcode byte boundary
    assign exact_end = cs_rise & (state_ff == ST_HOLD) & (bit_cnt_ff == 4'h0) & ~extra_ff;
    assign exec_resume = exact_end & (cmd_ff == RESUME_CMD) & ~perf_enhance_mode
        & (program_suspended_flag_ff | erase_suspended_flag_ff);
    assign exec_reset = exact_end & (cmd_ff == RESET_CMD) & arm_ff;
    assign exec_null = exact_end & (cmd_ff == NULL_CMD);
    assign load_byte = sclk_fall & ~cs_n_s & (state_ff == ST_DATA) & (out_cnt_ff == 4'h0);

    // link framing: opcode, address, dummy, data
    always_ff @(posedge clk) begin
        if (sys_rst || cs_n_s) begin
            state_ff <= ST_OPCODE;
            bit_cnt_ff <= 4'h0;
            byte_cnt_ff <= 2'h0;
            sh_ff <= 8'h00;
            extra_ff <= 1'b0;
            if (sys_rst) begin
                cmd_ff <= 8'h00;
                addr_ff <= 24'h000000;
            end
        end else begin
            if (take_bit) begin
                sh_ff <= nxt_sh;
                bit_cnt_ff <= byte_done ? 4'h0 : nxt_bits;
            end
            // address steps as each byte is loaded into the output shifter
            if (load_byte) begin
                addr_ff <= addr_ff + 24'h000001;
            end
            case (state_ff)
                ST_OPCODE: begin
                    if (byte_done) begin
                        cmd_ff <= nxt_sh;
                        byte_cnt_ff <= 2'h0;
                        state_ff <= (nxt_sh == PARAM_TABLE_READ_CMD) ? ST_ADDR : ST_HOLD;
                    end
                end
                ST_ADDR: begin
                    if (byte_done) begin
                        addr_ff <= {addr_ff[15:0], nxt_sh};
                        byte_cnt_ff <= byte_cnt_ff + 2'h1;
                        if (byte_cnt_ff == ADDR_BYTES - 2'h1) begin
                            state_ff <= ST_DUMMY;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (byte_done) begin
                        state_ff <= ST_DATA;
                    end
                end
                ST_HOLD: begin
                    if (take_bit) begin
                        extra_ff <= 1'b1;
                    end
                end
                ST_DATA: begin
                end
                default: begin
                    state_ff <= ST_OPCODE;
                end
            endcase
        end
    end

    // output shifter, new bits on falling link clock
    always_ff @(posedge clk) begin
        if (sys_rst || cs_n_s) begin
            out_sh_ff <= 8'h00;
            out_cnt_ff <= 4'h0;
            io_out_ff <= 4'h0;
            io_oe_ff <= 4'h0;
        end else if (sclk_fall && state_ff == ST_DATA) begin
            io_oe_ff <= qpi_mode ? QPI_OE : SPI_OE;
            if (out_cnt_ff == 4'h0) begin
                out_cnt_ff <= qpi_mode ? QPI_OUT_REST : SPI_OUT_REST;
                if (qpi_mode) begin
                    io_out_ff <= rom_byte[7:4];
                    out_sh_ff <= {rom_byte[3:0], 4'h0};
                end else begin
                    io_out_ff <= {2'h0, rom_byte[7], 1'b0};
                    out_sh_ff <= {rom_byte[6:0], 1'b0};
                end
            end else begin
                out_cnt_ff <= out_cnt_ff - 4'h1;
                if (qpi_mode) begin
                    io_out_ff <= out_sh_ff[7:4];
                    out_sh_ff <= {out_sh_ff[3:0], 4'h0};
                end else begin
                    io_out_ff <= {2'h0, out_sh_ff[7], 1'b0};
                    out_sh_ff <= {out_sh_ff[6:0], 1'b0};
                end
            end
        end
    end

    // reset arming
    always_ff @(posedge clk) begin
        if (sys_rst || exec_reset) begin
            arm_ff <= 1'b0;
        end else if (opcode_done && nxt_sh != RESET_ARM_CMD && nxt_sh != RESET_CMD) begin
            arm_ff <= 1'b0;
        end else if (exact_end) begin
            arm_ff <= (cmd_ff == RESET_ARM_CMD) ? 1'b1 : ((cmd_ff == RESET_CMD) ? 1'b0 : arm_ff);
        end
    end

    // suspend flags, a suspend set wins over a clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            program_suspended_flag_ff <= 1'b0;
            erase_suspended_flag_ff <= 1'b0;
        end else begin
            if (program_suspend_req) begin
                program_suspended_flag_ff <= 1'b1;
            end else if (exec_resume || exec_reset) begin
                program_suspended_flag_ff <= 1'b0;
            end
            if (erase_suspend_req) begin
                erase_suspended_flag_ff <= 1'b1;
            end else if (exec_resume || exec_reset) begin
                erase_suspended_flag_ff <= 1'b0;
            end
        end
    end

    // busy after resume, resume set wins over done
    always_ff @(posedge clk) begin
        if (sys_rst || exec_reset) begin
            busy_ff <= 1'b0;
        end else if (exec_resume) begin
            busy_ff <= 1'b1;
        end else if (write_done) begin
            busy_ff <= 1'b0;
        end
    end

    // event pulses to the array engine
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            resume_ff <= 1'b0;
            soft_reset_ff <= 1'b0;
            abort_ff <= 1'b0;
        end else begin
            resume_ff <= exec_resume;
            soft_reset_ff <= exec_reset;
            abort_ff <= exec_reset & op_in_progress;
        end
    end

    assign io_out = io_out_ff;
    assign io_oe = io_oe_ff;
    always_comb begin
        security_reg = 8'h00;
        security_reg[PROG_SUSP_BIT] = program_suspended_flag_ff;
        security_reg[ERASE_SUSP_BIT] = erase_suspended_flag_ff;
    end
    assign busy = busy_ff;
    assign resume_pulse = resume_ff;
    assign soft_reset_pulse = soft_reset_ff;
    assign abort_pulse = abort_ff;
    assign reset_armed = arm_ff;

    // opcodes seen since the last complete arm frame, saturating
    logic [1:0] ops_since_arm_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ops_since_arm_ff <= 2'h3;
        end else if (exact_end && cmd_ff == RESET_ARM_CMD) begin
            ops_since_arm_ff <= 2'h0;
        end else if (opcode_done && ops_since_arm_ff != 2'h3) begin
            ops_since_arm_ff <= ops_since_arm_ff + 2'h1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence resume_no_susp_s;
        exec_resume && !program_suspend_req && !erase_suspend_req;
    endsequence

    sequence arm_then_reset_s;
        exact_end && cmd_ff == RESET_CMD && ops_since_arm_ff == 2'h1;
    endsequence

    resume_clears_a: assert property (resume_no_susp_s
        |=> security_reg[3:2] == 2'b00 ##0 resume_pulse)
        else $error("resume did not clear suspend flags");
    resume_busy_a: assert property (exec_resume |=> busy ##1 (busy || $past(write_done)))
        else $error("busy not held after resume");
    perf_block_a: assert property (exact_end && cmd_ff == RESUME_CMD
        && perf_enhance_mode && !program_suspend_req && !erase_suspend_req
        |=> !resume_pulse && $stable(security_reg))
        else $error("resume taken while blocked");
    idle_resume_a: assert property (exact_end && cmd_ff == RESUME_CMD
        && security_reg[3:2] == 2'b00 && !write_done |=> !resume_pulse && $stable(busy))
        else $error("resume acted with nothing suspended");
    null_only_a: assert property (exec_null && !program_suspend_req && !erase_suspend_req
        |=> !reset_armed && $stable(security_reg) && !soft_reset_pulse)
        else $error("null command changed more than arming");
    reset_arm_a: assert property (soft_reset_pulse
        |-> $past(arm_ff) && $past(cmd_ff) == RESET_CMD)
        else $error("reset executed without arming");
    arm_reset_a: assert property (arm_then_reset_s |=> soft_reset_pulse)
        else $error("armed reset not executed");
    reset_default_a: assert property (soft_reset_pulse |-> !busy && !reset_armed)
        else $error("reset left volatile state");
    abort_op_a: assert property (exec_reset && op_in_progress
        |=> abort_pulse && soft_reset_pulse)
        else $error("reset did not abort operation");
    cs_release_a: assert property (cs_rise |=> io_oe == 4'h0 && state_ff == ST_OPCODE)
        else $error("output still driven after select high");
    addr_step_a: assert property (load_byte |=> addr_ff == $past(addr_ff) + 24'h000001)
        else $error("table address did not advance");
    sig_first_a: assert property (load_byte && addr_ff == 24'h000000 && !qpi_mode
        |=> io_out[1] == 1'b0 ##0 io_oe == SPI_OE)
        else $error("signature byte wrong");
endmodule

// ===== sim/host_link_model.sv
// host flash controller model: drives select, link clock and data lines
// assumes clk is the 40 MHz bench clock; the link clock is clk/8 (200 ns)
`timescale 1ns/1ps
module host_link_model (
    input wire logic clk,
    input wire logic qpi_mode,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe,
    output logic cs_n_pin,
    output logic sclk_pin,
    output logic [3:0] io_in
);
    logic [3:0] junk;

    initial begin
        cs_n_pin = 1'b1;
        sclk_pin = 1'b0;
        io_in = 4'h5;
        junk = 4'hA;
    end

    task automatic half();
        repeat (4) @(posedge clk);
    endtask

    task automatic frame_begin();
        @(posedge clk);
        cs_n_pin <= 1'b0;
        half();
    endtask

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        logic [3:0] seen;
        rx = 8'h00;
        for (int i = 0; i < (qpi_mode ? 2 : 8); i++) begin
            junk <= ~junk;
            io_in <= qpi_mode ? tx[7 - 4 * i -: 4] : {junk[3:1], tx[7 - i]};
            half();
            sclk_pin <= 1'b1;
            half();
            seen = (io_out & io_oe) | (junk & ~io_oe);
            rx = qpi_mode ? {rx[3:0], seen} : {rx[6:0], seen[1]};
            sclk_pin <= 1'b0;
        end
    endtask

    task automatic frame_end();
        half();
        cs_n_pin <= 1'b1;
        io_in <= ~io_in;
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask
endmodule

// ===== sim/tb.sv
// bench for the flash command interpreter: host model on the link, checks at ports
// assumes the package, the design files and the host link model are compiled first
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
    end \
end
module tb
    import flash_cmd_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic qpi_mode = 1'b0;
    logic perf_enhance_mode = 1'b0;
    logic program_suspend_req = 1'b0;
    logic erase_suspend_req = 1'b0;
    logic op_in_progress = 1'b0;
    logic write_done = 1'b0;
    logic cs_n_pin;
    logic sclk_pin;
    logic [3:0] io_in;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic [7:0] security_reg;
    logic busy;
    logic resume_pulse;
    logic soft_reset_pulse;
    logic abort_pulse;
    logic reset_armed;
    int error_cnt = 0;
    int samples_checked = 0;
    int resume_seen = 0;
    int reset_seen = 0;
    int abort_seen = 0;
    logic [7:0] rx;
    logic [7:0] exp_tbl [0:31] = '{
        8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h02, 8'hFF,
        8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hFF,
        MAKER_ID, 8'h00, 8'h01, 8'h04, 8'h10, 8'h01, 8'h00, 8'hFF,
        8'h84, 8'h00, 8'h01, 8'h02, 8'hC0, 8'h00, 8'h00, 8'hFF};

    always #12.5 clk = ~clk;

    flash_cmd_core u_dut (
        .clk(clk), .sys_rst(sys_rst), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
        .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .qpi_mode(qpi_mode),
        .perf_enhance_mode(perf_enhance_mode), .program_suspend_req(program_suspend_req),
        .erase_suspend_req(erase_suspend_req), .op_in_progress(op_in_progress),
        .write_done(write_done), .security_reg(security_reg), .busy(busy),
        .resume_pulse(resume_pulse), .soft_reset_pulse(soft_reset_pulse),
        .abort_pulse(abort_pulse), .reset_armed(reset_armed));

    host_link_model u_host (
        .clk(clk), .qpi_mode(qpi_mode), .io_out(io_out), .io_oe(io_oe),
        .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .io_in(io_in));

    // count cycles each pulse stands high; abort counted only while soft reset is high too
    always @(posedge clk) begin
        if (!sys_rst && resume_pulse !== 1'b0) resume_seen++;
        if (!sys_rst && soft_reset_pulse !== 1'b0) reset_seen++;
        if ((abort_pulse & soft_reset_pulse) === 1'b1) abort_seen++;
    end

    task automatic finish_test();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic step(input logic qpi, input logic perf, input logic op,
                        input logic [2:0] req);
        @(posedge clk);
        qpi_mode <= qpi;
        perf_enhance_mode <= perf;
        op_in_progress <= op;
        {program_suspend_req, erase_suspend_req, write_done} <= req;
        @(posedge clk);
        {program_suspend_req, erase_suspend_req, write_done} <= 3'b000;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic cmd(input logic [7:0] op);
        resume_seen = 0;
        reset_seen = 0;
        abort_seen = 0;
        u_host.frame_begin();
        u_host.xfer(op, rx);
        u_host.frame_end();
    endtask

    task automatic expect_state(input logic [7:0] sec, input logic bsy, input logic arm,
                                input int n_res, input int n_rst, input int n_abt);
        `CHK("security_reg", sec, security_reg)
        `CHK("busy", bsy, busy)
        `CHK("reset_armed", arm, reset_armed)
        `CHK("resume_pulse", n_res, resume_seen)
        `CHK("soft_reset_pulse", n_rst, reset_seen)
        `CHK("abort_pulse", n_abt, abort_seen)
    endtask

    task automatic rd_table(input logic [23:0] addr, input int n);
        u_host.frame_begin();
        u_host.xfer(PARAM_TABLE_READ_CMD, rx);
        for (int i = 2; i >= 0; i--) u_host.xfer(addr[8 * i +: 8], rx);
        u_host.xfer(8'h00, rx);
        for (int i = 0; i < n; i++) begin
            u_host.xfer(8'h00, rx);
            `CHK("table_byte", (addr + i < 32) ? exp_tbl[addr + i] : UNUSED_BYTE, rx)
        end
        `CHK("io_oe", qpi_mode ? QPI_OE : SPI_OE, io_oe)
        u_host.frame_end();
        `CHK("io_oe", 4'h0, io_oe)
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        finish_test();
    end

    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        expect_state(8'h00, 1'b0, 1'b0, 0, 0, 0);
        cmd(RESUME_CMD);
        expect_state(8'h00, 1'b0, 1'b0, 0, 0, 0);
        step(1'b0, 1'b0, 1'b0, 3'b100);
        expect_state(8'h04, 1'b0, 1'b0, 0, 0, 0);
        step(1'b0, 1'b1, 1'b0, 3'b000);
        cmd(RESUME_CMD);
        expect_state(8'h04, 1'b0, 1'b0, 0, 0, 0);
        step(1'b0, 1'b0, 1'b0, 3'b000);
        cmd(RESUME_CMD);
        expect_state(8'h00, 1'b1, 1'b0, 1, 0, 0);
        repeat (20) @(posedge clk);
        @(negedge clk);
        expect_state(8'h00, 1'b1, 1'b0, 1, 0, 0);
        step(1'b0, 1'b0, 1'b0, 3'b001);
        expect_state(8'h00, 1'b0, 1'b0, 1, 0, 0);
        step(1'b1, 1'b0, 1'b0, 3'b010);
        expect_state(8'h08, 1'b0, 1'b0, 1, 0, 0);
        cmd(RESUME_CMD);
        expect_state(8'h00, 1'b1, 1'b0, 1, 0, 0);
        step(1'b1, 1'b0, 1'b0, 3'b101);
        cmd(RESET_ARM_CMD);
        expect_state(8'h04, 1'b0, 1'b1, 0, 0, 0);
        cmd(NULL_CMD);
        expect_state(8'h04, 1'b0, 1'b0, 0, 0, 0);
        cmd(RESET_CMD);
        expect_state(8'h04, 1'b0, 1'b0, 0, 0, 0);
        step(1'b0, 1'b0, 1'b1, 3'b000);
        cmd(RESET_ARM_CMD);
        cmd(RESET_CMD);
        expect_state(8'h00, 1'b0, 1'b0, 0, 1, 1);
        cmd(RESET_ARM_CMD);
        cmd(WRITE_ENABLE_CMD);
        cmd(RESET_CMD);
        expect_state(8'h00, 1'b0, 1'b0, 0, 0, 0);
        u_host.frame_begin();
        u_host.xfer(RESET_ARM_CMD, rx);
        u_host.xfer(RESET_ARM_CMD, rx);
        u_host.frame_end();
        expect_state(8'h00, 1'b0, 1'b0, 0, 0, 0);
        step(1'b0, 1'b0, 1'b0, 3'b000);
        cmd(RESET_ARM_CMD);
        cmd(RESET_CMD);
        expect_state(8'h00, 1'b0, 1'b0, 0, 1, 0);
        rd_table(24'h000000, 33);
        step(1'b1, 1'b0, 1'b0, 3'b000);
        rd_table(24'h00001D, 4);
        finish_test();
    end
endmodule
